//--- src/sfb_regs.sv
// Purpose: byte-wide interrupt enable, flag and module enable bank
// Assumes: cpu strobes are on clk; peripheral events come from other logic or pins
// Notes:   absent bits read zero and ignore writes
`timescale 1ns/1ns
module sfb_regs (
	// clock and power-up clear
	input  wire logic                       clk,
	input  wire logic                       sys_rst,

	// cpu bus
	input  wire logic [sfb_pkg::ADDR_W-1:0] cpu_addr,
	input  wire logic                       cpu_rd,
	input  wire logic                       cpu_wr,
	input  wire logic [sfb_pkg::DATA_W-1:0] cpu_wdata,
	output logic      [sfb_pkg::DATA_W-1:0] cpu_rdata,

	// hardware events, one-cycle pulses on clk
	input  wire logic                       watchdog_overflow,
	input  wire logic                       watchdog_key_violation,
	input  wire logic                       reset_pin_event,
	input  wire logic                       osc_fault_detect,
	input  wire logic                       timer_counter_event,
	input  wire logic                       base_timer_event,
	input  wire logic                       serial_rx_event,
	input  wire logic                       serial_tx_event,

	// pin events, asynchronous levels
	input  wire logic                       nmi_pin_async,
	input  wire logic                       port0_bit0_async,
	input  wire logic                       port0_bit1_async,

	// timer/port request from its own module
	input  wire logic                       timerport_flag,

	// flag and request outputs
	output logic                            watchdog_event_flag,
	output logic                            osc_fault_flag,
	output logic                            nmi_pin_flag,
	output logic                            port0_bit0_flag,
	output logic                            port0_bit1_flag,
	output logic                            serial_rx_irq_req,
	output logic                            serial_tx_irq_req,
	output logic                            timerport_irq_req,
	output logic                            base_timer_irq_req,

	// module enables
	output logic                            serial_tx_module_en,
	output logic                            serial_rx_module_en
);
	import sfb_pkg::*;

	// register images; absent bits are held at zero by the masks
	logic [DATA_W-1:0] ie2_q;
	logic [DATA_W-1:0] if1_q;
	logic [DATA_W-1:0] if1_d;
	logic [DATA_W-1:0] if2_q;
	logic [DATA_W-1:0] if2_d;
	logic [DATA_W-1:0] me2_q;
	logic [DATA_W-1:0] if1_set;
	logic [DATA_W-1:0] if2_set;

	// pin edge detection
	logic [2:0]        pin_sync;
	logic [2:0]        pin_prev_q;
	logic [2:0]        pin_rise;

	// write decode
	logic              wr_ie2;
	logic              wr_if1;
	logic              wr_if2;
	logic              wr_me2;

	// pins are synchronised before edge detection
	// one synchroniser for all three pins keeps their stages aligned
	sfb_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.async_in({port0_bit1_async, port0_bit0_async, nmi_pin_async}),
		.sync_out(pin_sync)
	);

	// previous levels reset low: a pin held high through reset shows one edge after release
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_prev_q <= 3'h0;
		end else begin
			pin_prev_q <= pin_sync;
		end
	end

	assign pin_rise = pin_sync & ~pin_prev_q;

	// byte-wide memory decode
	// a read and a write at one edge both act; the read returns the old byte
	assign wr_ie2 = cpu_wr && (cpu_addr == IRQ_ENABLE_SECOND_OFS);
	assign wr_if1 = cpu_wr && (cpu_addr == IRQ_FLAG_FIRST_OFS);
	assign wr_if2 = cpu_wr && (cpu_addr == IRQ_FLAG_SECOND_OFS);
	assign wr_me2 = cpu_wr && (cpu_addr == MODULE_ENABLE_SECOND_OFS);

	// hardware set terms, one per flag bit
	always_comb begin
		if1_set = 8'h00;
		if1_set[WATCHDOG_EVENT_FLAG_BIT] = watchdog_overflow | watchdog_key_violation;
		if1_set[OSC_FAULT_FLAG_BIT]      = osc_fault_detect;
		if1_set[PORT0_BIT0_FLAG_BIT]     = pin_rise[1];
		// timer/counter and the port0 bit1 pin share flag bit 3
		if1_set[PORT0_BIT1_FLAG_BIT]     = pin_rise[2] | timer_counter_event;
		if1_set[NMI_PIN_FLAG_BIT]        = pin_rise[0];
	end

	// the transmit flag leaves reset set, so enabling its request fires at once
	always_comb begin
		if2_set = 8'h00;
		if2_set[SERIAL_RX_FLAG_BIT]  = serial_rx_event;
		if2_set[SERIAL_TX_FLAG_BIT]  = serial_tx_event;
		if2_set[BASE_TIMER_FLAG_BIT] = base_timer_event;
	end

	// hardware set wins over a software write in the same cycle
	always_comb begin
		if1_d = if1_q;
		// software write first, then hardware sets on top
		if (wr_if1) begin
			if1_d = cpu_wdata;
		end
		if1_d = (if1_d | if1_set) & IRQ_FLAG_FIRST_MASK;
		// a reset-pin condition clears the watchdog flag unless it fires now
		if (reset_pin_event && !if1_set[WATCHDOG_EVENT_FLAG_BIT]) begin
			if1_d[WATCHDOG_EVENT_FLAG_BIT] = 1'b0;
		end
	end

	always_comb begin
		if2_d = if2_q;
		if (wr_if2) begin
			if2_d = cpu_wdata;
		end
		if2_d = (if2_d | if2_set) & IRQ_FLAG_SECOND_MASK;
	end

	// first flag byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			if1_q <= IRQ_FLAG_FIRST_RST;
		end else begin
			if1_q <= if1_d;
		end
	end

	// second flag byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			if2_q <= IRQ_FLAG_SECOND_RST;
		end else begin
			if2_q <= if2_d;
		end
	end

	// enable byte; only the present bits are stored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ie2_q <= IRQ_ENABLE_SECOND_RST;
		end else if (wr_ie2) begin
			ie2_q <= cpu_wdata & IRQ_ENABLE_SECOND_MASK;
		end
	end

	// module enables hold until rewritten; the modules they gate sit outside this bank
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			me2_q <= MODULE_ENABLE_SECOND_RST;
		end else if (wr_me2) begin
			me2_q <= cpu_wdata & MODULE_ENABLE_SECOND_MASK;
		end
	end

	// registered read data; offsets 0h and 4h have no bits present
	// a read of an absent offset still updates cpu_rdata, to zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cpu_rdata <= ABSENT_READ;
		end else if (cpu_rd) begin
			case (cpu_addr)
				IRQ_ENABLE_SECOND_OFS:    cpu_rdata <= ie2_q;
				IRQ_FLAG_FIRST_OFS:       cpu_rdata <= if1_q;
				IRQ_FLAG_SECOND_OFS:      cpu_rdata <= if2_q;
				MODULE_ENABLE_SECOND_OFS: cpu_rdata <= me2_q;
				default:                  cpu_rdata <= ABSENT_READ;
			endcase
		end
	end

	// flag levels come straight from the register bits
	assign watchdog_event_flag = if1_q[WATCHDOG_EVENT_FLAG_BIT];
	assign osc_fault_flag      = if1_q[OSC_FAULT_FLAG_BIT];
	assign nmi_pin_flag        = if1_q[NMI_PIN_FLAG_BIT];
	assign port0_bit0_flag     = if1_q[PORT0_BIT0_FLAG_BIT];
	assign port0_bit1_flag     = if1_q[PORT0_BIT1_FLAG_BIT];

	// requests are and-gates of register bits (timer/port gates its input flag), one cycle behind a flag or enable write
	// timer/port keeps its own flags; only its enable lives in this bank
	assign serial_rx_irq_req  = if2_q[SERIAL_RX_FLAG_BIT] & ie2_q[SERIAL_RX_IRQ_EN_BIT];
	assign serial_tx_irq_req  = if2_q[SERIAL_TX_FLAG_BIT] & ie2_q[SERIAL_TX_IRQ_EN_BIT];
	assign timerport_irq_req  = timerport_flag & ie2_q[TIMERPORT_IRQ_EN_BIT];
	assign base_timer_irq_req = if2_q[BASE_TIMER_FLAG_BIT] & ie2_q[BASE_TIMER_IRQ_EN_BIT];

	// module enable levels
	assign serial_tx_module_en = me2_q[SERIAL_TX_MODULE_EN_BIT];
	assign serial_rx_module_en = me2_q[SERIAL_RX_MODULE_EN_BIT];
endmodule : sfb_regs

//--- src/sfb_pkg.sv
// Purpose: constants for the special function register bank
// Assumes: byte-wide registers at the lowest data addresses
// Notes:   bit positions follow the byte layouts of the bank
package sfb_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;

	// register offsets
	localparam logic [ADDR_W-1:0] IRQ_ENABLE_FIRST_OFS  = 4'h0;
	localparam logic [ADDR_W-1:0] IRQ_ENABLE_SECOND_OFS = 4'h1;
	localparam logic [ADDR_W-1:0] IRQ_FLAG_FIRST_OFS    = 4'h2;
	localparam logic [ADDR_W-1:0] IRQ_FLAG_SECOND_OFS   = 4'h3;
	localparam logic [ADDR_W-1:0] MODULE_ENABLE_FIRST_OFS  = 4'h4;
	localparam logic [ADDR_W-1:0] MODULE_ENABLE_SECOND_OFS = 4'h5;

	// irq_enable_second fields
	localparam int unsigned SERIAL_RX_IRQ_EN_BIT  = 0;
	localparam int unsigned SERIAL_TX_IRQ_EN_BIT  = 1;
	localparam int unsigned TIMERPORT_IRQ_EN_BIT  = 3;
	localparam int unsigned BASE_TIMER_IRQ_EN_BIT = 7;

	// irq_flag_first fields
	localparam int unsigned WATCHDOG_EVENT_FLAG_BIT = 0;
	localparam int unsigned OSC_FAULT_FLAG_BIT      = 1;
	localparam int unsigned PORT0_BIT0_FLAG_BIT     = 2;
	localparam int unsigned PORT0_BIT1_FLAG_BIT     = 3;
	localparam int unsigned NMI_PIN_FLAG_BIT        = 4;

	// irq_flag_second fields
	localparam int unsigned SERIAL_RX_FLAG_BIT  = 0;
	localparam int unsigned SERIAL_TX_FLAG_BIT  = 1;
	localparam int unsigned BASE_TIMER_FLAG_BIT = 7;

	// module_enable_second fields
	localparam int unsigned SERIAL_RX_MODULE_EN_BIT = 0;
	localparam int unsigned SERIAL_TX_MODULE_EN_BIT = 1;

	// implemented-bit masks
	localparam logic [DATA_W-1:0] IRQ_ENABLE_SECOND_MASK    = 8'h8b;
	localparam logic [DATA_W-1:0] IRQ_FLAG_FIRST_MASK       = 8'h1f;
	localparam logic [DATA_W-1:0] IRQ_FLAG_SECOND_MASK      = 8'h83;
	localparam logic [DATA_W-1:0] MODULE_ENABLE_SECOND_MASK = 8'h03;

	// values after power-up clear
	localparam logic [DATA_W-1:0] IRQ_ENABLE_SECOND_RST    = 8'h00;
	localparam logic [DATA_W-1:0] IRQ_FLAG_FIRST_RST       = 8'h02;
	localparam logic [DATA_W-1:0] IRQ_FLAG_SECOND_RST      = 8'h02;
	localparam logic [DATA_W-1:0] MODULE_ENABLE_SECOND_RST = 8'h00;

	// unimplemented bits and unmapped offsets read back as this
	localparam logic [DATA_W-1:0] ABSENT_READ = 8'h00;
endpackage : sfb_pkg

//--- src/sfb_sync.sv
// Purpose: two-stage synchroniser for a group of asynchronous event lines
// Assumes: inputs may change at any time relative to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module sfb_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// lines
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : sfb_sync

//--- bench/sfb_regs_assertions.sv
// Purpose: port-level checks of the special function register bank
// Assumes: sys_rst is the power-up clear, synchronous on clk
// Notes:   pin checks allow for the synchroniser plus edge detect
`timescale 1ns/1ns
module sfb_regs_assertions (
	// clock, reset and cpu bus
	input wire logic       clk, sys_rst, cpu_rd, cpu_wr,
	input wire logic [3:0] cpu_addr,
	input wire logic [7:0] cpu_wdata, cpu_rdata,
	// events and outputs
	input wire logic       watchdog_overflow, osc_fault_detect, timer_counter_event,
	input wire logic       port0_bit0_async, timerport_flag, watchdog_event_flag,
	input wire logic       osc_fault_flag, port0_bit0_flag, port0_bit1_flag,
	input wire logic       serial_rx_irq_req, serial_tx_irq_req, timerport_irq_req,
	input wire logic       serial_tx_module_en, serial_rx_module_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence pin0_rise;
		$rose(port0_bit0_async);
	endsequence
	pup_clear_a: assert property (disable iff (1'b0) sys_rst |=> !serial_tx_module_en
		&& !serial_rx_module_en && osc_fault_flag && cpu_rdata == 8'h00) else $error("reset value");
	module_en_a: assert property (cpu_wr && cpu_addr == 4'h5 |=>
		{serial_tx_module_en, serial_rx_module_en} == $past(cpu_wdata[1:0])) else $error("enable");
	wdog_set_a: assert property (watchdog_overflow |=> watchdog_event_flag) else $error("wdog");
	osc_set_a: assert property (osc_fault_detect |=> osc_fault_flag) else $error("osc");
	pin0_flag_a: assert property (pin0_rise |-> ##[0:4] port0_bit0_flag) else $error("pin0");
	tc_flag_a: assert property (timer_counter_event |=> port0_bit1_flag) else $error("tc");
	rx_gate_a: assert property (cpu_wr && cpu_addr == 4'h1 && !cpu_wdata[0] |=>
		!serial_rx_irq_req) else $error("rx gate");
	tx_gate_a: assert property (cpu_wr && cpu_addr == 4'h1 && !cpu_wdata[1] |=>
		!serial_tx_irq_req) else $error("tx gate");
	tp_gate_a: assert property (cpu_wr && cpu_addr == 4'h1 && !cpu_wdata[3] |=>
		!timerport_irq_req) else $error("tp gate");
	tp_pass_a: assert property (cpu_wr && cpu_addr == 4'h1 && cpu_wdata[3] |=>
		timerport_irq_req == timerport_flag) else $error("tp pass");
	absent_rd_a: assert property (cpu_rd && !(cpu_addr inside {1, 2, 3, 5}) |=>
		cpu_rdata == 8'h00) else $error("absent read");
endmodule : sfb_regs_assertions
bind sfb_regs sfb_regs_assertions i_chk (.*);

//--- bench/sfb_cpu_model.sv
// Purpose: cpu side of the bank's byte bus
// Assumes: one strobe per access, read answer one cycle later
// Notes:   idle lines carry inverted values so stale data is never trusted
`timescale 1ns/1ns
module sfb_cpu_model (
	// clock
	input  wire logic       clk,
	// bus towards the bank
	output logic      [3:0] cpu_addr,
	output logic            cpu_rd,
	output logic            cpu_wr,
	output logic      [7:0] cpu_wdata,
	// answer
	input  wire logic [7:0] cpu_rdata
);
	initial begin
		cpu_addr = 4'h0;
		cpu_rd = 1'b0;
		cpu_wr = 1'b0;
		cpu_wdata = 8'h00;
	end
	// called just after an edge; returns at an edge with the answer held
	task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= wr;
		cpu_rd <= !wr;
		@(posedge clk);
		cpu_addr <= ~a;
		cpu_wdata <= ~d;
		cpu_wr <= 1'b0;
		cpu_rd <= 1'b0;
		@(posedge clk);
		q = cpu_rdata;
	endtask : acc
endmodule : sfb_cpu_model

//--- bench/tb_top.sv
// Purpose: self-checking bench for the special function register bank
// Assumes: the cpu model issues one access at a time
// Notes:   event and pin lines share one vector so one loop covers every source except the reset pin, checked after it
`timescale 1ns/1ns
module tb_top;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        tp = 1'b0;
	logic [10:0] ev = '0;
	logic [10:0] o;
	logic [3:0]  cpu_addr, a;
	logic        cpu_rd, cpu_wr;
	logic [7:0]  cpu_wdata, cpu_rdata, q, d, f;
	int          fail_count = 0;
	int          total_checks = 0;
	logic [3:0]  ev_a [10] = '{2, 2, 2, 2, 3, 3, 3, 2, 2, 2};
	int          ev_b [10] = '{0, 0, 1, 3, 7, 0, 1, 4, 2, 3};
	initial forever #25 clk = ~clk;
	sfb_cpu_model i_cpu (.*);
	sfb_regs i_dut (.*, .watchdog_overflow(ev[0]), .watchdog_key_violation(ev[1]),
		.osc_fault_detect(ev[2]), .timer_counter_event(ev[3]), .base_timer_event(ev[4]),
		.serial_rx_event(ev[5]), .serial_tx_event(ev[6]), .nmi_pin_async(ev[7]),
		.port0_bit0_async(ev[8]), .port0_bit1_async(ev[9]), .reset_pin_event(ev[10]),
		.timerport_flag(tp), .watchdog_event_flag(o[0]), .osc_fault_flag(o[1]),
		.nmi_pin_flag(o[2]), .port0_bit0_flag(o[3]), .port0_bit1_flag(o[4]),
		.serial_rx_irq_req(o[5]), .serial_tx_irq_req(o[6]), .timerport_irq_req(o[7]),
		.base_timer_irq_req(o[8]), .serial_tx_module_en(o[9]), .serial_rx_module_en(o[10]));
	function automatic logic [7:0] msk(input logic [3:0] x);
		case (x)
			4'h1: return 8'h8b;
			4'h2: return 8'h1f;
			4'h3: return 8'h83;
			4'h5: return 8'h03;
			default: return 8'h00;
		endcase
	endfunction : msk
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	task rst_test;
		for (int i = 0; i < 16; i++) begin
			i_cpu.acc(1'b0, i[3:0], 8'h00, q);
			chk("reset value", (i == 2 || i == 3) ? 8'h02 : 8'h00, q);
		end
		$display("test reset done");
	endtask : rst_test
	task ev_test;
		for (int i = 0; i < 10; i++) begin
			i_cpu.acc(1'b1, 4'h2, 8'h00, q);
			i_cpu.acc(1'b1, 4'h3, 8'h00, q);
			ev[i] <= 1'b1;
			@(posedge clk);
			ev[i] <= 1'b0;
			repeat (5) @(posedge clk);
			i_cpu.acc(1'b0, ev_a[i], 8'h00, q);
			chk("event flag", 8'h01 << ev_b[i], q);
			f = {3'h0, o[2], o[4], o[3], o[1], o[0]};
			chk("flag pins", (ev_a[i] == 4'h2) ? 8'h01 << ev_b[i] : 8'h00, f);
		end
		i_cpu.acc(1'b1, 4'h2, 8'h01, q);
		ev[10] <= 1'b1;
		@(posedge clk);
		ev[10] <= 1'b0;
		i_cpu.acc(1'b0, 4'h2, 8'h00, q);
		chk("reset pin", 8'h00, q);
		ev[0] <= 1'b1;
		ev[10] <= 1'b1;
		@(posedge clk);
		ev[0] <= 1'b0;
		ev[10] <= 1'b0;
		i_cpu.acc(1'b0, 4'h2, 8'h00, q);
		chk("set beats clear", 8'h01, q);
		tp <= 1'b1;
		i_cpu.acc(1'b1, 4'h1, 8'h8b, q);
		i_cpu.acc(1'b1, 4'h3, 8'h83, q);
		chk("irq on", 8'h0f, {4'h0, o[8:5]});
		i_cpu.acc(1'b1, 4'h1, 8'h00, q);
		chk("irq off", 8'h00, {4'h0, o[8:5]});
		$display("test events done");
	endtask : ev_test
	initial begin
		void'($urandom(32'hfb8d));
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rst_test();
		ev_test();
		for (int n = 0; n < 24; n++) begin
			a = (n == 0) ? 4'h5 : 4'($urandom);
			d = (n == 0) ? 8'hff : 8'($urandom);
			tp <= 1'($urandom);
			i_cpu.acc(1'b1, a, d, q);
			i_cpu.acc(1'b0, a, 8'h00, q);
			chk("readback", d & msk(a), q);
			if (a == 4'h5) chk("module en", {6'h0, d[1:0]}, {6'h0, o[9], o[10]});
		end
		$display("test random done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rst_test();
		end_sim();
	end
	// hang guard: counts as a mismatch
	initial begin
		#2000000;
		fail_count++;
		end_sim();
	end
endmodule : tb_top
